/* common/pmv_map.vh */
`ifndef PMV_MAP_VH
`define PMV_MAP_VH
// register indices; the byte address is four times the index
`define PMV_IDX_P1_MIRROR 8'h11
`define PMV_IDX_P1_POLICY 8'h12
`define PMV_IDX_P2_MIRROR 8'h21
`define PMV_IDX_P2_POLICY 8'h22
`define PMV_IDX_P3_MIRROR 8'h31
`define PMV_IDX_P3_POLICY 8'h32
`define PMV_IDX_P4_MIRROR 8'h41
`define PMV_IDX_P4_POLICY 8'h42
`define PMV_IDX_P5_MIRROR 8'h51
`define PMV_IDX_P5_POLICY 8'h52
// index layout: port number in the high nibble, register in the low
`define PMV_IDX_PORT_HI 7
`define PMV_IDX_PORT_LO 4
`define PMV_IDX_REG_HI 3
`define PMV_IDX_REG_LO 0
`define PMV_REG_MIRROR 4'h1
`define PMV_REG_POLICY 4'h2
`define PMV_PORT_FIRST 4'h1
`define PMV_PORT_SEL_HI 2
`define PMV_PORT_SEL_LO 0
`define PMV_SRC_FALLBACK 3'h0
// bus field positions and fill values
`define PMV_ADR_IDX_HI 9
`define PMV_ADR_IDX_LO 2
`define PMV_SEL_LANE0 0
`define PMV_DATA_HI 7
`define PMV_DATA_LO 0
`define PMV_BYTE_ZERO 8'h00
`define PMV_DAT_PAD 24'h00_0000
`define PMV_DAT_ZERO 32'h0000_0000
// mirror/membership register fields
`define PMV_BIT_MONITOR 7
`define PMV_BIT_RX_MIRROR 6
`define PMV_BIT_TX_MIRROR 5
`define PMV_MEMB_HI 4
`define PMV_MEMB_LO 0
// policy register fields
`define PMV_BIT_PRIO_CEIL 7
`define PMV_BIT_IN_FILTER 6
`define PMV_BIT_NONPVID_DROP 5
`define PMV_BIT_FORCE_FC 4
`define PMV_POLICY_MASK 8'hf0
// reset values
`define PMV_MIRROR_RST 8'h1f
`define PMV_POLICY_RST 8'h00
`endif

/* design/pmv_port_ctrl.v */
// Summary of operation
// [RULE1] monitor-port bit makes a port send monitored frame copies; resets clear
// [RULE2] receive-mirror bit copies every frame received on port to monitor port; here a dropped frame gets no copy
// [RULE3] transmit-mirror bit copies every frame sent from port to monitor port
// [RULE4] five-bit membership mask, bit4 port5 to bit0 port1, resets all ones
// [RULE5] forward only to destinations included in ingress port membership mask
// [RULE6] ceiling bit replaces frame priority above default-tag priority with it
// [RULE7] ingress filtering drops frames whose vlan table members exclude ingress port
// [RULE8] discard bit drops frames whose vlan id differs from port default id
// [RULE9] forced flow control enables rx and tx pause regardless of negotiation
// [RULE10] monitoring, ceiling, filtering, discard bits all reset to zero
// [RULE11] default vlan id is the ingress port configured identifier
// [RULE12] mirror copy is in addition to normal forwarding, never a replacement
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/100ps
`include "pmv_map.vh"
module pmv_port_ctrl #(
  parameter NPORT = 5,
  parameter VIDW = 12,
  parameter PRIW = 3
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [9:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output reg err_o,
  // frame decision request, from forwarding logic on this clock
  input wire dec_valid_i,
  input wire [2:0] dec_src_i,
  input wire [NPORT-1:0] dec_dst_i,
  input wire [NPORT-1:0] dec_tx_i,
  input wire [VIDW-1:0] dec_vid_i,
  input wire [PRIW-1:0] dec_pri_i,
  input wire [NPORT-1:0] dec_vlan_memb_i,
  // per-port default tag, owned by neighbouring registers
  input wire [NPORT*VIDW-1:0] port_default_vlan_id_i,
  input wire [NPORT*PRIW-1:0] port_default_pri_i,
  // auto-negotiated pause result per port
  input wire [NPORT-1:0] an_rx_fc_i,
  input wire [NPORT-1:0] an_tx_fc_i,
  // frame decision result
  output reg dec_valid_o,
  output reg dec_drop_o,
  output reg [NPORT-1:0] dec_fwd_o,
  output reg dec_monitored_o,
  output reg [PRIW-1:0] dec_pri_o,
  // per-port configuration levels
  output reg [NPORT-1:0] monitor_port_o,
  output reg [NPORT-1:0] rx_fc_en_o,
  output reg [NPORT-1:0] tx_fc_en_o
);
  localparam ST_IDLE = 2'b01;
  localparam ST_ANSWER = 2'b10;

  // configuration storage, one mirror and one policy byte per port
  reg [7:0] mirror_r [0:NPORT-1];
  reg [7:0] policy_r [0:NPORT-1];

  // bus answer state
  reg [1:0] bus_state_r;
  reg [1:0] bus_state_nxt;
  reg ack_nxt;
  reg err_nxt;
  reg [31:0] dat_nxt;
  reg [7:0] rd_byte;

  // negotiated pause comes from the line side: two flops before any use
  reg [NPORT-1:0] an_rx_meta_r;
  reg [NPORT-1:0] an_rx_sync_r;
  reg [NPORT-1:0] an_tx_meta_r;
  reg [NPORT-1:0] an_tx_sync_r;

  // per-port control bits gathered into vectors
  wire [NPORT-1:0] monitor_bits;
  wire [NPORT-1:0] rx_mirror_bits;
  wire [NPORT-1:0] tx_mirror_bits;
  wire [NPORT-1:0] prio_ceil_bits;
  wire [NPORT-1:0] in_filter_bits;
  wire [NPORT-1:0] nonpvid_drop_bits;
  wire [NPORT-1:0] force_fc_bits;
  wire [NPORT-1:0] monitor_nxt;
  wire [NPORT-1:0] rx_fc_nxt;
  wire [NPORT-1:0] tx_fc_nxt;

  // per-port default tag fields
  wire [VIDW-1:0] port_default_vlan_id_arr [0:NPORT-1];
  wire [PRIW-1:0] ppri_arr [0:NPORT-1];

  // address decode
  wire [7:0] idx = adr_i[`PMV_ADR_IDX_HI:`PMV_ADR_IDX_LO];
  wire [3:0] port_nib = idx[`PMV_IDX_PORT_HI:`PMV_IDX_PORT_LO];
  wire [3:0] reg_nib = idx[`PMV_IDX_REG_HI:`PMV_IDX_REG_LO];
  wire [3:0] port_off = port_nib - `PMV_PORT_FIRST;
  wire [2:0] port_sel = port_off[`PMV_PORT_SEL_HI:`PMV_PORT_SEL_LO];
  wire port_ok = (port_nib >= `PMV_PORT_FIRST) && (port_off < NPORT);
  wire hit_mir = port_ok && (reg_nib == `PMV_REG_MIRROR);
  wire hit_pol = port_ok && (reg_nib == `PMV_REG_POLICY);
  wire hit = hit_mir || hit_pol;
  wire bus_req = cyc_i && stb_i;
  wire take = bus_req && (bus_state_r == ST_IDLE);
  wire lane0 = sel_i[`PMV_SEL_LANE0];
  // a write lands only at the edge where the master sees ack high
  wire wr = bus_req && we_i && ack_o && lane0 && hit;
  wire wr_mir = wr && hit_mir;
  wire wr_pol = wr && hit_pol;

  // read byte of the addressed register; zero when nothing is hit
  always @* begin
    rd_byte = `PMV_BYTE_ZERO;
    if (hit_mir)
      rd_byte = mirror_r[port_sel];
    else if (hit_pol)
      rd_byte = policy_r[port_sel];
  end

  // answer one cycle after the request is taken
  always @* begin
    bus_state_nxt = bus_state_r;
    ack_nxt = 1'b0;
    err_nxt = 1'b0;
    dat_nxt = `PMV_DAT_ZERO;
    case (bus_state_r)
      ST_IDLE: begin
        if (take) begin
          bus_state_nxt = ST_ANSWER;
          ack_nxt = hit;
          err_nxt = !hit;
          if (!we_i)
            dat_nxt = {`PMV_DAT_PAD, rd_byte};
        end
      end
      // the master releases after the answer, so nothing is taken here
      ST_ANSWER: begin
        bus_state_nxt = ST_IDLE;
      end
      default: begin
        bus_state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      bus_state_r <= ST_IDLE;
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= `PMV_DAT_ZERO;
    end else begin
      bus_state_r <= bus_state_nxt;
      ack_o <= ack_nxt;
      err_o <= err_nxt;
      dat_o <= dat_nxt;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NPORT; g = g + 1) begin : g_port
      wire sel_this = (port_sel == g);
      // [RULE4] [RULE10] mirror reset value
      always @(posedge clk_i) begin
        if (rst_i) begin
          mirror_r[g] <= `PMV_MIRROR_RST;
        end else if (wr_mir && sel_this) begin
          mirror_r[g] <= dat_i[`PMV_DATA_HI:`PMV_DATA_LO];
        end
      end
      // [RULE10] policy reset; reserved low bits always read zero
      always @(posedge clk_i) begin
        if (rst_i) begin
          policy_r[g] <= `PMV_POLICY_RST;
        end else if (wr_pol && sel_this) begin
          policy_r[g] <= dat_i[`PMV_DATA_HI:`PMV_DATA_LO] & `PMV_POLICY_MASK;
        end
      end
      // [RULE1] monitor port bit
      assign monitor_bits[g] = mirror_r[g][`PMV_BIT_MONITOR];
      // [RULE2] receive mirror bit
      assign rx_mirror_bits[g] = mirror_r[g][`PMV_BIT_RX_MIRROR];
      // [RULE3] transmit mirror bit
      assign tx_mirror_bits[g] = mirror_r[g][`PMV_BIT_TX_MIRROR];
      // [RULE6] priority ceiling bit
      assign prio_ceil_bits[g] = policy_r[g][`PMV_BIT_PRIO_CEIL];
      // [RULE7] ingress filter bit
      assign in_filter_bits[g] = policy_r[g][`PMV_BIT_IN_FILTER];
      // [RULE8] non-default id discard bit
      assign nonpvid_drop_bits[g] = policy_r[g][`PMV_BIT_NONPVID_DROP];
      // [RULE9] forced flow control bit
      assign force_fc_bits[g] = policy_r[g][`PMV_BIT_FORCE_FC];
      // [RULE11] default tag slice of this port
      assign port_default_vlan_id_arr[g] = port_default_vlan_id_i[g*VIDW +: VIDW];
      assign ppri_arr[g] = port_default_pri_i[g*PRIW +: PRIW];
    end
  endgenerate

  // [RULE9] negotiated pause, synchronised
  always @(posedge clk_i) begin
    if (rst_i) begin
      an_rx_meta_r <= {NPORT{1'b0}};
      an_rx_sync_r <= {NPORT{1'b0}};
      an_tx_meta_r <= {NPORT{1'b0}};
      an_tx_sync_r <= {NPORT{1'b0}};
    end else begin
      an_rx_meta_r <= an_rx_fc_i;
      an_rx_sync_r <= an_rx_meta_r;
      an_tx_meta_r <= an_tx_fc_i;
      an_tx_sync_r <= an_tx_meta_r;
    end
  end

  // [RULE9] forced bit overrides the negotiated result
  assign rx_fc_nxt = force_fc_bits | an_rx_sync_r;
  assign tx_fc_nxt = force_fc_bits | an_tx_sync_r;
  // [RULE1] monitor level follows its register bit
  assign monitor_nxt = monitor_bits;

  // levels registered so they move in step with the decision outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      monitor_port_o <= {NPORT{1'b0}};
      rx_fc_en_o <= {NPORT{1'b0}};
      tx_fc_en_o <= {NPORT{1'b0}};
    end else begin
      monitor_port_o <= monitor_nxt;
      rx_fc_en_o <= rx_fc_nxt;
      tx_fc_en_o <= tx_fc_nxt;
    end
  end

  // frame decision: one cycle from dec_valid_i to dec_valid_o
  reg [2:0] src;
  reg [7:0] src_mirror;
  reg [VIDW-1:0] port_default_vlan_id;
  reg [PRIW-1:0] ppri;
  reg src_rx_mirror;
  reg src_filter;
  reg src_nonpvid;
  reg src_ceil;
  reg [NPORT-1:0] src_memb;
  reg member_ok;
  reg vid_ok;
  reg drop_nxt;
  reg mon_nxt;
  reg [NPORT-1:0] fwd_nxt;
  reg [PRIW-1:0] pri_nxt;

  // out-of-range ingress numbers fall back to the first port
  always @* begin
    src = (dec_src_i < NPORT) ? dec_src_i : `PMV_SRC_FALLBACK;
  end

  // settings of the ingress port
  always @* begin
    src_mirror = mirror_r[src];
    // [RULE11] default id of the ingress port
    port_default_vlan_id = port_default_vlan_id_arr[src];
    ppri = ppri_arr[src];
    src_rx_mirror = rx_mirror_bits[src];
    src_filter = in_filter_bits[src];
    src_nonpvid = nonpvid_drop_bits[src];
    src_ceil = prio_ceil_bits[src];
    src_memb = src_mirror[`PMV_MEMB_HI:`PMV_MEMB_LO];
    member_ok = dec_vlan_memb_i[src];
    vid_ok = (dec_vid_i == port_default_vlan_id);
  end

  always @* begin
    drop_nxt = 1'b0;
    // [RULE7] ingress filter
    if (src_filter && !member_ok)
      drop_nxt = 1'b1;
    // [RULE8] non-default id discard
    if (src_nonpvid && !vid_ok)
      drop_nxt = 1'b1;
    // [RULE5] membership gate
    fwd_nxt = dec_dst_i & src_memb;
    // [RULE2] [RULE3] monitored when received on, or sent from, a mirrored port
    mon_nxt = src_rx_mirror || (|(tx_mirror_bits & fwd_nxt));
    // [RULE12] copy added to the normal path
    if (mon_nxt)
      fwd_nxt = fwd_nxt | monitor_bits;
    // a dropped frame gets no copy either
    if (drop_nxt) begin
      fwd_nxt = {NPORT{1'b0}};
      mon_nxt = 1'b0;
    end
    // [RULE6] priority ceiling
    pri_nxt = dec_pri_i;
    if (src_ceil && (dec_pri_i > ppri))
      pri_nxt = ppri;
  end

  // results are held between decisions for the forwarding logic
  always @(posedge clk_i) begin
    if (rst_i) begin
      dec_valid_o <= 1'b0;
      dec_drop_o <= 1'b0;
      dec_fwd_o <= {NPORT{1'b0}};
      dec_monitored_o <= 1'b0;
      dec_pri_o <= {PRIW{1'b0}};
    end else begin
      dec_valid_o <= dec_valid_i;
      if (dec_valid_i) begin
        dec_drop_o <= drop_nxt;
        dec_fwd_o <= fwd_nxt;
        dec_monitored_o <= mon_nxt;
        dec_pri_o <= pri_nxt;
      end
    end
  end
endmodule

/* testbench/pmv_port_ctrl_sva.sv */
`timescale 1ns/100ps
module pmv_chk (
  input wire clk_i, rst_i, ack_o, err_o, dec_valid_i, dec_valid_o,
  input wire dec_drop_o, dec_monitored_o,
  input wire [2:0] dec_pri_i, dec_pri_o,
  input wire [4:0] dec_dst_i, dec_fwd_o, monitor_port_o, an_rx_fc_i, rx_fc_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property ((ack_o || err_o) |=> !ack_o && !err_o)
    else $error("answer too long");
  a_dec_latency: assert property (dec_valid_i |=> dec_valid_o)
    else $error("no decision");
  a_fwd_member: assert property (dec_valid_o && !dec_drop_o |->
    (dec_fwd_o & ~($past(dec_dst_i) | monitor_port_o)) == 0)
    else $error("bad forward");
  a_copy_added: assert property (dec_valid_o && dec_monitored_o |->
    (monitor_port_o & ~dec_fwd_o) == 0)
    else $error("copy missing");
  a_drop_clears: assert property (dec_valid_o && dec_drop_o |-> dec_fwd_o == 0)
    else $error("dropped frame sent");
  a_pri_ceiling: assert property (dec_valid_o |-> dec_pri_o <= $past(dec_pri_i))
    else $error("priority raised");
  a_fc_negotiated: assert property (($past(an_rx_fc_i, 3) & ~rx_fc_en_o) == 0)
    else $error("pause lost");
  a_monitor_reset: assert property ($past(rst_i) |-> monitor_port_o == 0)
    else $error("monitor set");
  cover property (err_o);
  cover property (dec_valid_o && dec_monitored_o);
  cover property (dec_valid_o && dec_drop_o);
endmodule
bind pmv_port_ctrl pmv_chk u_chk (.*);

/* testbench/port_mirror_vlan_policy_ctrl_tb_top.sv */
`timescale 1ns/100ps
module port_mirror_vlan_policy_ctrl_tb_top;
  reg clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, dec_valid_i = 0, seen_err;
  reg [9:0] adr_i = 0;
  reg [3:0] sel_i = 4'h1;
  reg [31:0] dat_i = 0, rd;
  reg [2:0] dec_src_i = 0, dec_pri_i = 0;
  reg [4:0] dec_dst_i = 0, dec_vlan_memb_i = 0, an_rx_fc_i = 0, an_tx_fc_i = 0;
  reg [11:0] dec_vid_i = 0;
  wire ack_o, err_o, dec_valid_o, dec_drop_o, dec_monitored_o;
  wire [31:0] dat_o;
  wire [4:0] dec_fwd_o, monitor_port_o, rx_fc_en_o, tx_fc_en_o;
  wire [2:0] dec_pri_o;
  int error_cnt = 0, checked = 0, cyc_n = 0;
  pmv_port_ctrl dut (.*, .dec_tx_i(5'h00),
    .port_default_vlan_id_i({12'h005, 12'h004, 12'h003, 12'h002, 12'h00a}),
    .port_default_pri_i({5{3'h2}}));
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) if (++cyc_n == 3000) begin error_cnt++; conclude(); end
  task conclude();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, g);
    checked++;
    if (e !== g) begin error_cnt++; $display("MISMATCH %s exp %h got %h", n, e, g); end
  endtask
  task bus(input w, input [7:0] idx, input [31:0] d, e);
    cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= {idx, 2'b00}; dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1 && err_o !== 1) @(posedge clk_i);
    rd = dat_o;
    seen_err = err_o;
    cyc_i <= 0; stb_i <= 0;
    @(posedge clk_i);
    if (!w) chk("read", e, rd);
  endtask
  // decision result packed as valid, drop, monitored, fwd, pri
  task dec(input [4:0] dst, m, input [11:0] v, input [2:0] p, input [10:0] e);
    dec_valid_i <= 1; dec_dst_i <= dst; dec_vlan_memb_i <= m; dec_vid_i <= v; dec_pri_i <= p;
    @(posedge clk_i); dec_valid_i <= 0;
    @(posedge clk_i);
    chk("decision", e, {dec_valid_o, dec_drop_o, dec_monitored_o, dec_fwd_o, dec_pri_o});
  endtask
  task t_reset();
    for (int p = 1; p < 6; p++) begin
      bus(0, {p[3:0], 4'h1}, 0, 32'h1f);
      bus(0, {p[3:0], 4'h2}, 0, 32'h00);
    end
    chk("monitor", 0, monitor_port_o);
    $display("reset test done");
  endtask
  task t_regs();
    bus(1, 8'h32, 32'hff, 0);
    bus(0, 8'h32, 0, 32'hf0);
    bus(1, 8'h31, 32'h9f, 0);
    bus(0, 8'h31, 0, 32'h9f);
    bus(1, 8'h13, 32'hff, 0);
    chk("unmapped", 1, seen_err);
    chk("monitor", 5'h04, monitor_port_o);
    $display("register test done");
  endtask
  task t_mirror();
    bus(1, 8'h11, 32'h02, 0);
    dec(5'h1d, 5'h1f, 12'h00a, 3'h1, {3'b100, 5'h00, 3'h1});
    dec(5'h1f, 5'h1f, 12'h00a, 3'h1, {3'b100, 5'h02, 3'h1});
    bus(1, 8'h11, 32'h42, 0);
    dec(5'h1f, 5'h1f, 12'h00a, 3'h1, {3'b101, 5'h06, 3'h1});
    bus(1, 8'h11, 32'h02, 0);
    bus(1, 8'h21, 32'h3f, 0);
    dec(5'h1f, 5'h1f, 12'h00a, 3'h1, {3'b101, 5'h06, 3'h1});
    $display("mirror test done");
  endtask
  task t_policy();
    bus(1, 8'h12, 32'h40, 0);
    dec(5'h1f, 5'h1e, 12'h00a, 3'h1, {3'b110, 5'h00, 3'h1});
    dec(5'h1f, 5'h01, 12'h00a, 3'h1, {3'b101, 5'h06, 3'h1});
    bus(1, 8'h12, 32'h20, 0);
    dec(5'h1f, 5'h1e, 12'h00b, 3'h1, {3'b110, 5'h00, 3'h1});
    bus(1, 8'h12, 32'h80, 0);
    dec(5'h1f, 5'h1e, 12'h00b, 3'h3, {3'b101, 5'h06, 3'h2});
    dec(5'h1f, 5'h1e, 12'h00b, 3'h2, {3'b101, 5'h06, 3'h2});
    bus(1, 8'h22, 32'h20, 0);
    dec_src_i <= 3'h1;
    dec(5'h1f, 5'h1f, 12'h002, 3'h1, {3'b101, 5'h1f, 3'h1});
    dec(5'h1f, 5'h1f, 12'h00a, 3'h1, {3'b110, 5'h00, 3'h1});
    dec_src_i <= 3'h0;
    an_rx_fc_i <= 5'h01;
    an_tx_fc_i <= 5'h10;
    repeat (4) @(posedge clk_i);
    chk("rx pause", 5'h05, rx_fc_en_o);
    chk("tx pause", 5'h14, tx_fc_en_o);
    $display("policy test done");
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    t_reset();
    t_regs();
    t_mirror();
    t_policy();
    conclude();
  end
endmodule
